// File: hw/ppt_pkg.sv
// constants and types for the pfc/pwm timing and protection sequencer
package ppt_pkg;
  // clock and delays
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BROWNOUT_MS = 1000;
  localparam int unsigned SAG_MS = 33;
  localparam int unsigned BROWNOUT_CYC = (CLK_HZ / 1000) * BROWNOUT_MS;
  localparam int unsigned SAG_CYC = (CLK_HZ / 1000) * SAG_MS;
  localparam int CNT_W = 24;
  localparam logic [1:0] DIV_RST = 2'h0;
  // sequencer states of the pwm stage
  typedef enum logic [2:0] {
    PPT_PWM_OFF = 3'b001,
    PPT_PWM_SOFT = 3'b010,
    PPT_PWM_RUN = 3'b100
  } ppt_pwm_state_t;
  // comparator indications, already active-true
  typedef struct packed {
    logic pfc_ilim;     // pfc sense below negative limit
    logic rms_low;      // line rms below lower brownout level
    logic rms_high;     // line rms above restart level
    logic rms_sag;      // line rms below sag level
    logic fb_low;       // converter feedback below offset
    logic pwm_ilim;     // converter current above limit
    logic input_good;   // boost feedback above good level
    logic input_off;    // boost feedback below input-off level
    logic ss_done;      // soft-start reached enable level
  } ppt_cmp_t;
endpackage

// File: hw/ppt_sync.sv
// two-flop synchroniser for a bundle of comparator levels
`timescale 1ns/10ps
module ppt_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // levels
  input wire ppt_pkg::ppt_cmp_t async_in,
  output ppt_pkg::ppt_cmp_t sync_out
);
  ppt_pkg::ppt_cmp_t meta_reg;

  // first stage read only by second stage
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// File: hw/ppt_top.sv
// pfc/pwm timing divider, gate interleave at equal ratio and protection sequencer
`timescale 1ns/10ps
module ppt_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // configuration: 0 equal ratio, 1 pwm at twice pfc rate
  input wire logic pwm_double_rate,
  // comparator indications from the analog side
  input wire logic pfc_current_sense_low,
  input wire logic line_rms_sense_low,
  input wire logic line_rms_sense_high,
  input wire logic sag_threshold_low,
  input wire logic converter_feedback_low,
  input wire logic converter_current_limit_high,
  input wire logic input_good_compare,
  input wire logic boost_output_feedback_off,
  input wire logic soft_start_done,
  // pfc modulator request: pulse wanted this cycle
  input wire logic pfc_demand,
  // gate drives
  output logic pfc_gate,
  output logic pwm_gate,
  // status
  output logic pfc_clk,
  output logic pwm_clk,
  output logic brownout,
  output logic sag_trip,
  output logic pwm_soft_start
);
  ppt_pkg::ppt_cmp_t cmp_raw;
  ppt_pkg::ppt_cmp_t cmp;
  logic [1:0] div_reg;
  logic [1:0] div_next;
  logic pwm_first_half;
  logic pwm_cycle_start;
  logic pfc_cycle_start;
  logic pfc_ilim_reg;
  logic pwm_ilim_reg;
  logic [ppt_pkg::CNT_W-1:0] bo_cnt_reg;
  logic [ppt_pkg::CNT_W-1:0] sag_cnt_reg;
  logic pfc_en;
  logic pwm_run;
  logic div_sel_reg;
  ppt_pkg::ppt_pwm_state_t pwm_state_reg;
  ppt_pkg::ppt_pwm_state_t pwm_state_next;

  // bundle the comparator pins
  assign cmp_raw = '{
    pfc_ilim: pfc_current_sense_low,
    rms_low: line_rms_sense_low,
    rms_high: line_rms_sense_high,
    rms_sag: sag_threshold_low,
    fb_low: converter_feedback_low,
    pwm_ilim: converter_current_limit_high,
    input_good: input_good_compare,
    input_off: boost_output_feedback_off,
    ss_done: soft_start_done
  };

  // pins cross into the clock domain before any logic reads them
  ppt_sync u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(cmp_raw),
    .sync_out(cmp)
  );

  // ratio strap caught after reset release, not by the async reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_sel_reg <= 1'b0;
    end else begin
      div_sel_reg <= pwm_double_rate;
    end
  end

  // toggle chain: bit0 toggles every edge, bit1 on bit0 carry
  assign div_next = {div_reg[1] ^ div_reg[0], ~div_reg[0]};
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_reg <= ppt_pkg::DIV_RST;
    end else begin
      div_reg <= div_next;
    end
  end

  // first half of each period from divider bits; tolerance set by flops
  assign pwm_first_half = div_sel_reg ? ~div_reg[0] : ~div_reg[1];
  assign pfc_cycle_start = (div_reg == 2'h3);
  assign pwm_cycle_start = div_sel_reg ? div_reg[0] : (div_reg == 2'h3);

  // divided clocks out for observation
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pfc_clk <= 1'b0;
      pwm_clk <= 1'b0;
    end else begin
      pfc_clk <= ~div_next[1];
      pwm_clk <= div_sel_reg ? ~div_next[0] : ~div_next[1];
    end
  end

  // brownout debounce counter; resets when the low indication clears
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bo_cnt_reg <= '0;
    end else if (!cmp.rms_low) begin
      bo_cnt_reg <= '0;
    end else if (bo_cnt_reg < ppt_pkg::CNT_W'(ppt_pkg::BROWNOUT_CYC)) begin
      bo_cnt_reg <= bo_cnt_reg + 1'b1;
    end
  end

  // brownout latch with hysteresis: set after debounce, clear above high level
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      brownout <= 1'b0;
    end else if (bo_cnt_reg == ppt_pkg::CNT_W'(ppt_pkg::BROWNOUT_CYC)) begin
      brownout <= 1'b1;
    end else if (cmp.rms_high) begin
      brownout <= 1'b0;
    end
  end

  // sag delay counter
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sag_cnt_reg <= '0;
    end else if (!cmp.rms_sag) begin
      sag_cnt_reg <= '0;
    end else if (sag_cnt_reg < ppt_pkg::CNT_W'(ppt_pkg::SAG_CYC)) begin
      sag_cnt_reg <= sag_cnt_reg + 1'b1;
    end
  end

  // sag latch; a new trip wins over the release
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sag_trip <= 1'b0;
    end else if (sag_cnt_reg == ppt_pkg::CNT_W'(ppt_pkg::SAG_CYC)) begin
      sag_trip <= 1'b1;
    end else if (cmp.rms_sag && cmp.input_off) begin
      sag_trip <= 1'b1;
    end else if (cmp.rms_high) begin
      sag_trip <= 1'b0;
    end
  end

  assign pfc_en = !brownout && !sag_trip;

  // pwm sequencing: off until input good, soft-start, then run
  always_comb begin
    pwm_state_next = pwm_state_reg;
    case (pwm_state_reg)
      ppt_pkg::PPT_PWM_OFF: begin
        if (cmp.input_good && !sag_trip) begin
          pwm_state_next = ppt_pkg::PPT_PWM_SOFT;
        end
      end
      ppt_pkg::PPT_PWM_SOFT: begin
        if (sag_trip || cmp.input_off) begin
          pwm_state_next = ppt_pkg::PPT_PWM_OFF;
        end else if (cmp.ss_done) begin
          pwm_state_next = ppt_pkg::PPT_PWM_RUN;
        end
      end
      ppt_pkg::PPT_PWM_RUN: begin
        if (sag_trip || cmp.input_off) begin
          pwm_state_next = ppt_pkg::PPT_PWM_OFF;
        end
      end
      default: pwm_state_next = ppt_pkg::PPT_PWM_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pwm_state_reg <= ppt_pkg::PPT_PWM_OFF;
    end else begin
      pwm_state_reg <= pwm_state_next;
    end
  end

  assign pwm_run = (pwm_state_reg == ppt_pkg::PPT_PWM_RUN);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pwm_soft_start <= 1'b0;
    end else begin
      pwm_soft_start <= (pwm_state_next == ppt_pkg::PPT_PWM_SOFT);
    end
  end

  // cycle-by-cycle limit latches; a new cycle start clears them
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pfc_ilim_reg <= 1'b0;
    end else if (cmp.pfc_ilim) begin
      pfc_ilim_reg <= 1'b1;
    end else if (pfc_cycle_start) begin
      pfc_ilim_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pwm_ilim_reg <= 1'b0;
    end else if (cmp.pwm_ilim) begin
      pwm_ilim_reg <= 1'b1;
    end else if (pwm_cycle_start) begin
      pwm_ilim_reg <= 1'b0;
    end
  end

  // pfc gate lives in the second half so its fall meets the pwm rise
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pfc_gate <= 1'b0;
    end else begin
      pfc_gate <= pfc_en && pfc_demand && div_next[1]
                  && !cmp.pfc_ilim && !pfc_ilim_reg;
    end
  end

  // pwm gate only in first half of its period, never past half duty, except for one cycle at a ratio change
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pwm_gate <= 1'b0;
    end else begin
      pwm_gate <= pwm_run && !cmp.fb_low && !cmp.pwm_ilim && !pwm_ilim_reg
                  && (div_sel_reg ? ~div_next[0] : ~div_next[1]);
    end
  end

  // pwm gate can only be high in the first half of its period; a ratio change skews one cycle
  chk_pwm_half_duty: assert property (@(posedge sys_clk) disable iff (reset)
    (pwm_gate && $stable(div_sel_reg)) |-> pwm_first_half)
    else $error("pwm gate outside first half");

  // brownout raises pfc gate low next cycle
  chk_brownout_gate: assert property (@(posedge sys_clk) disable iff (reset)
    brownout |=> !pfc_gate)
    else $error("pfc gate active during brownout");

  // sag stops both gates
  chk_sag_stops: assert property (@(posedge sys_clk) disable iff (reset)
    sag_trip |=> ##1 (!pwm_gate && !pfc_gate))
    else $error("gate active during sag trip");

  // pfc current limit blocks rest of cycle
  chk_pfc_limit: assert property (@(posedge sys_clk) disable iff (reset)
    cmp.pfc_ilim |=> !pfc_gate)
    else $error("pfc gate after current limit");

  // pwm current limit holds gate off until cycle start
  chk_pwm_limit: assert property (@(posedge sys_clk) disable iff (reset)
    (pwm_ilim_reg && !pwm_cycle_start) |=> !pwm_gate)
    else $error("pwm gate during current limit");

  // zero duty on low converter feedback
  chk_fb_zero: assert property (@(posedge sys_clk) disable iff (reset)
    cmp.fb_low |=> !pwm_gate)
    else $error("pwm gate with low feedback");

  // pwm never switches outside run state
  chk_pwm_seq: assert property (@(posedge sys_clk) disable iff (reset)
    !pwm_run |=> !pwm_gate)
    else $error("pwm gate before soft-start done");

  // gates never overlap in equal-ratio mode
  chk_interleave: assert property (@(posedge sys_clk) disable iff (reset)
    (!div_sel_reg && !$past(div_sel_reg)) |-> !(pfc_gate && pwm_gate))
    else $error("pfc and pwm gates overlap");

  // debounce expiry sets the brownout latch
  chk_bo_debounce: assert property (@(posedge sys_clk) disable iff (reset)
    (bo_cnt_reg == ppt_pkg::CNT_W'(ppt_pkg::BROWNOUT_CYC)) |=> brownout)
    else $error("brownout not set after debounce");

  // input-off stops a running pwm stage
  chk_input_off: assert property (@(posedge sys_clk) disable iff (reset)
    (pwm_run && cmp.input_off) |=> !pwm_run)
    else $error("pwm still running after input-off");
endmodule

// File: bench/ppt_stage_model.sv
// behavioural power stage: line, boost bus, soft-start cap and overload
`timescale 1ns/10ps
module ppt_stage_model #(
  parameter int SS_CYC = 20
) (
  // clock
  input wire logic sys_clk,
  // scenario knobs: 0 sag,1 low,2 mid,3 nominal line; 0 off,1 low,2 good bus
  input wire logic [1:0] line_v,
  input wire logic [1:0] bus_v,
  input wire logic overload,
  input wire logic fb_low,
  // device state seen by the stage
  input wire logic pwm_soft_start,
  // comparator levels
  output ppt_pkg::ppt_cmp_t cmp
);
  int ss_cnt = 0;
  // cap charges only in soft-start; a collapsing bus dumps it
  always @(posedge sys_clk) begin
    if (bus_v != 2'h2) ss_cnt <= 0;
    else if (pwm_soft_start && ss_cnt < SS_CYC) ss_cnt <= ss_cnt + 1;
  end
  // overload is a hard short: current over the limit however short the pulse
  always_comb begin
    cmp.rms_high = line_v == 2'h3;
    cmp.rms_low = line_v < 2'h2;
    cmp.rms_sag = line_v == 2'h0;
    cmp.input_good = bus_v == 2'h2;
    cmp.input_off = bus_v == 2'h0;
    cmp.pfc_ilim = overload;
    cmp.pwm_ilim = overload;
    cmp.fb_low = fb_low;
    cmp.ss_done = ss_cnt >= SS_CYC;
  end
endmodule

// File: bench/test_ppt_top.sv
// self-checking bench for the pfc/pwm timing and protection sequencer
`timescale 1ns/10ps
module test_ppt_top;
  logic sys_clk, reset, rate, overload, fb_low, demand;
  logic [1:0] line_v, bus_v;
  logic pfc_gate, pwm_gate, pfc_clk, pwm_clk, brownout, sag_trip, pwm_soft_start;
  ppt_pkg::ppt_cmp_t cmp;
  logic [7:0] n_pwm, n_pfc, r_pwm, r_pfc, bad_il;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  ppt_stage_model #(.SS_CYC(20)) u_stage (.sys_clk(sys_clk), .line_v(line_v),
    .bus_v(bus_v), .overload(overload), .fb_low(fb_low),
    .pwm_soft_start(pwm_soft_start), .cmp(cmp));
  ppt_top u_dut (.sys_clk(sys_clk), .reset(reset), .pwm_double_rate(rate),
    .pfc_current_sense_low(cmp.pfc_ilim), .line_rms_sense_low(cmp.rms_low),
    .line_rms_sense_high(cmp.rms_high), .sag_threshold_low(cmp.rms_sag),
    .converter_feedback_low(cmp.fb_low), .converter_current_limit_high(cmp.pwm_ilim),
    .input_good_compare(cmp.input_good), .boost_output_feedback_off(cmp.input_off),
    .soft_start_done(cmp.ss_done), .pfc_demand(demand), .pfc_gate(pfc_gate),
    .pwm_gate(pwm_gate), .pfc_clk(pfc_clk), .pwm_clk(pwm_clk), .brownout(brownout),
    .sag_trip(sag_trip), .pwm_soft_start(pwm_soft_start));
  // 100 ns oscillator clock
  always #50 sys_clk = ~sys_clk;
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %0h want %0h", $time, what, seen, exp);
    end
  endtask
  task automatic skip(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // counts gate highs, divided clock rises and misaligned pwm turn-ons
  task automatic watch(input int n);
    logic pp, pf, pc, fc;
    {n_pwm, n_pfc, r_pwm, r_pfc, bad_il} = '0;
    repeat (n) begin
      {pp, pf, pc, fc} = {pwm_gate, pfc_gate, pwm_clk, pfc_clk};
      @(negedge sys_clk);
      n_pwm += {7'h0, pwm_gate === 1'b1};
      n_pfc += {7'h0, pfc_gate === 1'b1};
      r_pwm += {7'h0, !pc && pwm_clk === 1'b1};
      r_pfc += {7'h0, !fc && pfc_clk === 1'b1};
      if (!pp && pwm_gate === 1'b1 && !(pf && pfc_gate === 1'b0)) bad_il++;
    end
  endtask
  task automatic t_clocks();
    watch(16);
    check(r_pfc, 8'h04, "pfc clk rate");
    check(r_pwm, 8'h04, "pwm clk rate");
    check(n_pwm, 8'h00, "pwm held, bus low");
    check(n_pfc, 8'h08, "pfc pulses");
    rate = 1'b1;
    skip(4);
    watch(16);
    check(r_pwm, 8'h08, "pwm clk x2");
    check(r_pfc, 8'h04, "pfc clk x2 mode");
    rate = 1'b0;
  endtask
  task automatic t_start();
    bus_v = 2'h2;
    skip(6);
    check({7'h0, pwm_soft_start}, 8'h01, "soft-start entered");
    watch(10);
    check(n_pwm, 8'h00, "no pwm in soft-start");
    skip(20);
    watch(16);
    check({7'h0, pwm_soft_start}, 8'h00, "soft-start left");
    check(n_pwm, 8'h08, "pwm half duty");
    check(bad_il, 8'h00, "pfc off at pwm on");
    rate = 1'b1;
    skip(4);
    watch(16);
    check(n_pwm, 8'h08, "pwm half duty x2");
    rate = 1'b0;
    skip(4);
  endtask
  task automatic t_limits();
    fb_low = 1'b1;
    skip(4);
    watch(16);
    check(n_pwm, 8'h00, "zero duty at low feedback");
    fb_low = 1'b0;
    overload = 1'b1;
    skip(4);
    watch(16);
    check({7'h0, n_pwm < 8'h08}, 8'h01, "pwm limited");
    check({7'h0, n_pfc < 8'h08}, 8'h01, "pfc limited");
    overload = 1'b0;
    skip(6);
    watch(16);
    check(n_pwm, 8'h08, "pwm back next cycle");
    check(n_pfc, 8'h08, "pfc back next cycle");
  endtask
  task automatic t_off_sag();
    bus_v = 2'h0;
    skip(6);
    watch(16);
    check(n_pwm, 8'h00, "pwm stopped, bus off");
    check({7'h0, sag_trip}, 8'h00, "no sag at good line");
    line_v = 2'h0;
    skip(6);
    check({7'h0, sag_trip}, 8'h01, "sag at once");
    {line_v, bus_v} = 4'h6;
    skip(30);
    watch(16);
    check({7'h0, sag_trip}, 8'h01, "sag held, no restart");
    check(n_pfc + n_pwm, 8'h00, "both stopped");
    line_v = 2'h3;
    skip(6);
    check({7'h0, sag_trip}, 8'h00, "sag released");
  endtask
  task automatic t_brown();
    line_v = 2'h1;
    skip(300);
    watch(16);
    check({7'h0, brownout}, 8'h00, "brownout debounced");
    check(n_pfc, 8'h08, "pfc runs in debounce");
    line_v = 2'h3;
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {sys_clk, reset, rate, overload, fb_low, demand} = 6'h11;
    {line_v, bus_v} = 4'hd;
    skip(6);
    check({6'h0, pfc_gate, pwm_gate}, 8'h00, "gates in reset");
    check({6'h0, brownout, sag_trip}, 8'h00, "latches in reset");
    reset = 1'b0;
    skip(4);
    t_clocks();
    t_start();
    t_limits();
    t_off_sag();
    t_brown();
    summarize();
  end
endmodule
